// File: hw/kpi_pkg.sv
// package: register map, field layout, reset values and bus types of the keypad interrupt unit
package kpi_pkg;

	// ==========================================================
	// geometry
	localparam int KPI_MAX_PINS  = 8;
	localparam int KPI_NUM_PINS  = 4;
	localparam int KPI_REG_W     = 8;
	localparam int KPI_ADDR_W    = 12;
	localparam int KPI_DATA_W    = 32;

	// ==========================================================
	// register byte addresses
	localparam logic [KPI_ADDR_W-1:0] KPI_OFS_STATUS_CONTROL = 12'h000;
	localparam logic [KPI_ADDR_W-1:0] KPI_OFS_PIN_ENABLE     = 12'h004;
	localparam logic [KPI_ADDR_W-1:0] KPI_OFS_EDGE_SELECT    = 12'h008;

	// ==========================================================
	// status and control field positions
	localparam int KPI_BIT_DETECT_MODE = 0;
	localparam int KPI_BIT_IRQ_ENABLE  = 1;
	localparam int KPI_BIT_ACKNOWLEDGE = 2;
	localparam int KPI_BIT_EVENT_FLAG  = 3;

	// ==========================================================
	// reset values
	localparam logic [KPI_REG_W-1:0] KPI_RST_PIN_ENABLE  = 8'h00;
	localparam logic [KPI_REG_W-1:0] KPI_RST_EDGE_SELECT = 8'h00;
	localparam logic                 KPI_RST_IRQ_ENABLE  = 1'b0;
	localparam logic                 KPI_RST_DETECT_MODE = 1'b0;

	// ==========================================================
	// bus answers
	localparam logic [1:0] KPI_RESP_OKAY   = 2'h0;
	localparam logic [1:0] KPI_RESP_SLVERR = 2'h2;

	// ==========================================================
	// bus carriers
	typedef struct packed {
		logic [KPI_ADDR_W-1:0] awaddr;
		logic                  awvalid;
		logic [KPI_DATA_W-1:0] wdata;
		logic [3:0]            wstrb;
		logic                  wvalid;
		logic                  bready;
		logic [KPI_ADDR_W-1:0] araddr;
		logic                  arvalid;
		logic                  rready;
	} kpi_axi_req_s;

	typedef struct packed {
		logic                  awready;
		logic                  wready;
		logic [1:0]            bresp;
		logic                  bvalid;
		logic                  arready;
		logic [KPI_DATA_W-1:0] rdata;
		logic [1:0]            rresp;
		logic                  rvalid;
	} kpi_axi_rsp_s;

endpackage

// File: hw/kpi_top.sv
// keypad pin interrupt unit with an axi4-lite register slave
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// ==========================================================
// Operation
// RULE_01 - up to eight independently enabled key sources
// RULE_02 - only four key pins physically present
// RULE_03 - edge only or edge plus level sensing
// RULE_04 - control bits 7:4 read zero
// RULE_05 - bit 3 event flag, writes ignored
// RULE_06 - bit 2 write-one acknowledge, reads zero
// RULE_07 - bit 1 enables the cpu request
// RULE_08 - bit 0 selects edge or edge-level mode
// RULE_09 - pin enable register, one bit per pin
// RULE_10 - edge select register, one polarity per pin
// RULE_11 - three 8-bit software registers
// RULE_12 - keeps working in wait, wakes cpu
// RULE_13 - keeps detecting in light stop, wakes cpu
// RULE_14 - deep stop disables and resets the unit
// RULE_15 - debug mode changes nothing
// RULE_16 - edges found from two successive bus samples
// RULE_17 - all inputs idle before next edge
// RULE_18 - event sets flag, acknowledge clears it
// RULE_19 - level mode: acknowledge fails while asserted
// RULE_20 - polarity 0 falling/low, 1 rising/high
// RULE_21 - request equals flag and enable
module kpi_top
	import kpi_pkg::*;
#(
	parameter int NUM_PINS = KPI_NUM_PINS
)(
	// clock and reset
	input  wire logic          CLOCK,
	input  wire logic          RST_B,
	// register bus
	input  wire kpi_axi_req_s  AXI_REQ,
	output kpi_axi_rsp_s       AXI_RSP,
	// power mode from the system controller, same clock
	input  wire logic          DEEP_STOP,
	// key pins, asynchronous
	input  wire logic [NUM_PINS-1:0] KEY_INPUT_PINS,
	// requests to the cpu
	output logic               KEY_IRQ,
	output logic               WAKE_REQ
);

	// ==========================================================
	// pin synchroniser
	// absent pin positions are tied low, the active level at polarity 0; their enables still store
	logic [KPI_MAX_PINS-1:0] sync1_ff;
	logic [KPI_MAX_PINS-1:0] sync2_ff;
	logic [KPI_MAX_PINS-1:0] nxt_sync1;
	logic [KPI_MAX_PINS-1:0] nxt_sync2;

	always_comb begin
		nxt_sync1 = '0;
		nxt_sync1[NUM_PINS-1:0] = KEY_INPUT_PINS; // RULE_02
		nxt_sync2 = sync1_ff;
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
		end
	end

	// ==========================================================
	// axi4-lite slave
	logic [KPI_ADDR_W-1:0] aw_addr_ff;
	logic                  aw_have_ff;
	logic [KPI_DATA_W-1:0] w_data_ff;
	logic [3:0]            w_strb_ff;
	logic                  w_have_ff;
	kpi_axi_rsp_s          rsp_ff;
	logic [KPI_ADDR_W-1:0] nxt_aw_addr;
	logic                  nxt_aw_have;
	logic [KPI_DATA_W-1:0] nxt_w_data;
	logic [3:0]            nxt_w_strb;
	logic                  nxt_w_have;
	kpi_axi_rsp_s          nxt_rsp;
	logic                  wr_fire;
	logic                  wr_hit;
	logic [KPI_REG_W-1:0]  rd_val;
	logic                  rd_hit;

	// unit registers, read by the bus mux
	logic [KPI_REG_W-1:0] pin_enable_bits_ff;
	logic [KPI_REG_W-1:0] polarity_bits_ff;
	logic                 irq_enable_bit_ff;
	logic                 detect_level_mode_ff;
	logic                 key_event_flag_ff;

	function automatic logic addr_mapped(input logic [KPI_ADDR_W-1:0] a);
		addr_mapped = (a == KPI_OFS_STATUS_CONTROL) || (a == KPI_OFS_PIN_ENABLE) ||
			(a == KPI_OFS_EDGE_SELECT); // RULE_11
	endfunction

	always_comb begin
		rd_val = '0;
		// ack reads zero and the top nibble is unused
		case (AXI_REQ.araddr)
			KPI_OFS_STATUS_CONTROL: begin
				rd_val[KPI_BIT_EVENT_FLAG]  = key_event_flag_ff;     // RULE_05
				rd_val[KPI_BIT_IRQ_ENABLE]  = irq_enable_bit_ff;     // RULE_07
				rd_val[KPI_BIT_DETECT_MODE] = detect_level_mode_ff;  // RULE_08
			end // RULE_04 RULE_06
			KPI_OFS_PIN_ENABLE:  rd_val = pin_enable_bits_ff;
			KPI_OFS_EDGE_SELECT: rd_val = polarity_bits_ff;
			default:             rd_val = '0;
		endcase
		rd_hit = addr_mapped(AXI_REQ.araddr);
	end

	always_comb begin
		nxt_aw_addr = aw_addr_ff;
		nxt_aw_have = aw_have_ff;
		nxt_w_data  = w_data_ff;
		nxt_w_strb  = w_strb_ff;
		nxt_w_have  = w_have_ff;
		nxt_rsp     = rsp_ff;
		// address and data are taken independently, in either order
		if (AXI_REQ.awvalid && rsp_ff.awready) begin
			nxt_aw_addr = AXI_REQ.awaddr;
			nxt_aw_have = 1'b1;
		end
		if (AXI_REQ.wvalid && rsp_ff.wready) begin
			nxt_w_data = AXI_REQ.wdata;
			nxt_w_strb = AXI_REQ.wstrb;
			nxt_w_have = 1'b1;
		end
		if (rsp_ff.bvalid && AXI_REQ.bready) begin
			nxt_rsp.bvalid = 1'b0;
		end
		// the write lands only once the previous response is gone
		wr_fire = aw_have_ff && w_have_ff && !rsp_ff.bvalid;
		wr_hit  = wr_fire && addr_mapped(aw_addr_ff) && w_strb_ff[0];
		if (wr_fire) begin
			nxt_aw_have    = 1'b0;
			nxt_w_have     = 1'b0;
			nxt_rsp.bvalid = 1'b1;
			nxt_rsp.bresp  = addr_mapped(aw_addr_ff) ? KPI_RESP_OKAY : KPI_RESP_SLVERR;
		end
		nxt_rsp.awready = !nxt_aw_have;
		nxt_rsp.wready  = !nxt_w_have;
		// read channel: one outstanding read
		if (rsp_ff.rvalid && AXI_REQ.rready) begin
			nxt_rsp.rvalid = 1'b0;
			nxt_rsp.rdata  = '0;
		end
		if (AXI_REQ.arvalid && rsp_ff.arready) begin
			nxt_rsp.rvalid = 1'b1;
			nxt_rsp.rdata  = {{(KPI_DATA_W-KPI_REG_W){1'b0}}, rd_val};
			nxt_rsp.rresp  = rd_hit ? KPI_RESP_OKAY : KPI_RESP_SLVERR;
		end
		nxt_rsp.arready = !nxt_rsp.rvalid;
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			aw_addr_ff <= '0;
			aw_have_ff <= 1'b0;
			w_data_ff  <= '0;
			w_strb_ff  <= '0;
			w_have_ff  <= 1'b0;
			rsp_ff     <= '{awready: 1'b1, wready: 1'b1, bresp: KPI_RESP_OKAY,
				bvalid: 1'b0, arready: 1'b1, rdata: '0, rresp: KPI_RESP_OKAY,
				rvalid: 1'b0};
		end else begin
			aw_addr_ff <= nxt_aw_addr;
			aw_have_ff <= nxt_aw_have;
			w_data_ff  <= nxt_w_data;
			w_strb_ff  <= nxt_w_strb;
			w_have_ff  <= nxt_w_have;
			rsp_ff     <= nxt_rsp;
		end
	end

	assign AXI_RSP = rsp_ff;

	// ==========================================================
	// key detection core
	logic [KPI_REG_W-1:0] prev_ff;
	logic                 armed_ff;
	logic                 irq_ff;
	logic [KPI_REG_W-1:0] nxt_pin_enable;
	logic [KPI_REG_W-1:0] nxt_polarity;
	logic                 nxt_irq_enable;
	logic                 nxt_detect_mode;
	logic                 nxt_flag;
	logic [KPI_REG_W-1:0] nxt_prev;
	logic                 nxt_armed;
	logic                 nxt_irq;
	logic [KPI_REG_W-1:0] now_act;
	logic [KPI_REG_W-1:0] was_act;
	logic                 any_act;
	logic                 edge_seen;
	logic                 level_seen;
	logic                 ack_wr;
	logic [KPI_REG_W-1:0] pin_now;
	logic [KPI_REG_W-1:0] pin_was;

	// ==========================================================
	// per-pin sensing
	// a pin counts only when present and enabled; polarity 0 means active low
	for (genvar g = 0; g < KPI_MAX_PINS; g++) begin : g_pin
		if (g < NUM_PINS) begin : g_present
			assign pin_now[g] = pin_enable_bits_ff[g] && (sync2_ff[g] == polarity_bits_ff[g]); // RULE_20
			assign pin_was[g] = pin_enable_bits_ff[g] && (prev_ff[g] == polarity_bits_ff[g]);
		end else begin : g_absent
			// no input here: the enable stores but must never sense a tied level
			assign pin_now[g] = 1'b0; // RULE_02
			assign pin_was[g] = 1'b0;
		end
	end

	always_comb begin
		now_act = pin_now;                                               // RULE_09 RULE_10
		was_act = pin_was;                                               // RULE_16
		any_act = |now_act;
		// a new edge only counts once every enabled pin has gone idle
		edge_seen  = armed_ff && |(now_act & ~was_act);                 // RULE_17 RULE_01
		level_seen = detect_level_mode_ff && any_act;                   // RULE_03
		ack_wr     = wr_hit && (aw_addr_ff == KPI_OFS_STATUS_CONTROL) &&
			w_data_ff[KPI_BIT_ACKNOWLEDGE];                              // RULE_06

		nxt_pin_enable  = pin_enable_bits_ff;
		nxt_polarity    = polarity_bits_ff;
		nxt_irq_enable  = irq_enable_bit_ff;
		nxt_detect_mode = detect_level_mode_ff;
		if (wr_hit) begin
			case (aw_addr_ff)
				KPI_OFS_STATUS_CONTROL: begin
					nxt_irq_enable  = w_data_ff[KPI_BIT_IRQ_ENABLE];   // RULE_07
					nxt_detect_mode = w_data_ff[KPI_BIT_DETECT_MODE];  // RULE_08
				end
				KPI_OFS_PIN_ENABLE:  nxt_pin_enable = w_data_ff[KPI_REG_W-1:0];
				KPI_OFS_EDGE_SELECT: nxt_polarity   = w_data_ff[KPI_REG_W-1:0];
				default: begin
					nxt_pin_enable = pin_enable_bits_ff;
				end
			endcase
		end

		// set beats acknowledge; in level mode an asserted pin re-sets at once
		nxt_flag  = edge_seen || level_seen || (key_event_flag_ff && !ack_wr); // RULE_18 RULE_19 RULE_05
		nxt_armed = edge_seen ? 1'b0 : (armed_ff || !any_act);
		nxt_prev  = sync2_ff;
		// wait, light stop and debug need nothing special: the unit stays clocked
		nxt_irq   = nxt_flag && nxt_irq_enable;                            // RULE_21 RULE_12 RULE_13 RULE_15

		// deep stop holds the unit in its reset condition
		if (DEEP_STOP) begin                                               // RULE_14
			nxt_pin_enable  = KPI_RST_PIN_ENABLE;
			nxt_polarity    = KPI_RST_EDGE_SELECT;
			nxt_irq_enable  = KPI_RST_IRQ_ENABLE;
			nxt_detect_mode = KPI_RST_DETECT_MODE;
			nxt_flag        = 1'b0;
			nxt_armed       = 1'b0;
			nxt_irq         = 1'b0;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			pin_enable_bits_ff   <= KPI_RST_PIN_ENABLE;
			polarity_bits_ff     <= KPI_RST_EDGE_SELECT;
			irq_enable_bit_ff    <= KPI_RST_IRQ_ENABLE;
			detect_level_mode_ff <= KPI_RST_DETECT_MODE;
			key_event_flag_ff    <= 1'b0;
			prev_ff              <= '0;
			armed_ff             <= 1'b0;
			irq_ff               <= 1'b0;
		end else begin
			pin_enable_bits_ff   <= nxt_pin_enable;
			polarity_bits_ff     <= nxt_polarity;
			irq_enable_bit_ff    <= nxt_irq_enable;
			detect_level_mode_ff <= nxt_detect_mode;
			key_event_flag_ff    <= nxt_flag;
			prev_ff              <= nxt_prev;
			armed_ff             <= nxt_armed;
			irq_ff               <= nxt_irq;
		end
	end

	assign KEY_IRQ  = irq_ff;
	assign WAKE_REQ = irq_ff;

endmodule

// File: bench/kpi_keys.sv
// partner: key switches driving the key pins of the unit
`timescale 1ns/1ps
module kpi_keys
	import kpi_pkg::*;
(
	// clock
	input  wire logic                    clock,
	// levels asked for by the bench
	input  wire logic [KPI_NUM_PINS-1:0] want,
	// key pins
	output logic [KPI_NUM_PINS-1:0]      pins
);
	// ==========================================================
	// switches
	// levels move just after an edge and stay whole cycles, starting idle high
	logic [KPI_NUM_PINS-1:0] pins_ff = '1;
	always @(posedge clock) begin
		pins_ff <= want;
	end
	assign pins = pins_ff;
endmodule

// File: bench/kpi_properties.sv
// checker: port-level properties of the keypad interrupt unit
`timescale 1ns/1ps
module kpi_properties
	import kpi_pkg::*;
#(
	parameter int NUM_PINS = KPI_NUM_PINS
)(
	// clock and reset
	input wire logic                CLOCK,
	input wire logic                RST_B,
	// register bus
	input wire kpi_axi_req_s        AXI_REQ,
	input wire kpi_axi_rsp_s        AXI_RSP,
	// power and key pins
	input wire logic                DEEP_STOP,
	input wire logic [NUM_PINS-1:0] KEY_INPUT_PINS,
	// requests
	input wire logic                KEY_IRQ,
	input wire logic                WAKE_REQ
);
	// ==========================================================
	// read target, remembered so read data can be judged
	logic ctl_rd_ff;
	logic nxt_ctl_rd;
	wire  ar_take = AXI_REQ.arvalid && AXI_RSP.arready;
	always_comb begin
		nxt_ctl_rd = ar_take ? (AXI_REQ.araddr == KPI_OFS_STATUS_CONTROL) : ctl_rd_ff;
	end
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) ctl_rd_ff <= 1'b0;
		else ctl_rd_ff <= nxt_ctl_rd;
	end
	wire ctl_rd = AXI_RSP.rvalid && ctl_rd_ff;
	// ==========================================================
	// properties
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	a_wake_follows: assert property (WAKE_REQ == KEY_IRQ)
		else $error("wake differs from irq");
	a_deep_quiet: assert property (DEEP_STOP [*2] |-> !KEY_IRQ)
		else $error("irq during deep stop");
	a_ctl_reserved: assert property (ctl_rd |-> AXI_RSP.rdata[7:4] == 4'h0 && !AXI_RSP.rdata[2])
		else $error("control reads reserved or ack bits set");
	a_upper_zero: assert property (AXI_RSP.rvalid |-> AXI_RSP.rdata[31:8] == 24'h0)
		else $error("read data above byte 0");
	a_irq_masked: assert property (ctl_rd && !AXI_RSP.rdata[1] |-> !KEY_IRQ)
		else $error("irq while disabled");
	a_irq_raised: assert property (ctl_rd && AXI_RSP.rdata[3] && AXI_RSP.rdata[1] |-> KEY_IRQ)
		else $error("irq missing with flag and enable");
	a_write_answer: assert property (AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid && AXI_RSP.wready |-> ##[1:3] AXI_RSP.bvalid)
		else $error("no write response");
	a_read_answer: assert property (ar_take |=> AXI_RSP.rvalid)
		else $error("no read response");
	a_aw_refused: assert property (AXI_REQ.awvalid && AXI_RSP.awready |=> !AXI_RSP.awready)
		else $error("address taken twice");
endmodule
bind kpi_top kpi_properties #(.NUM_PINS(NUM_PINS)) i_props (.CLOCK(CLOCK), .RST_B(RST_B),
	.AXI_REQ(AXI_REQ), .AXI_RSP(AXI_RSP), .DEEP_STOP(DEEP_STOP),
	.KEY_INPUT_PINS(KEY_INPUT_PINS), .KEY_IRQ(KEY_IRQ), .WAKE_REQ(WAKE_REQ));

// File: bench/testbench.sv
// testbench: bus, detection and deep stop checks of the keypad unit
`timescale 1ns/1ps
module testbench
	import kpi_pkg::*;
;
	localparam logic [11:0] r_ctl = KPI_OFS_STATUS_CONTROL;
	localparam logic [11:0] r_pen = KPI_OFS_PIN_ENABLE;
	localparam logic [11:0] r_pol = KPI_OFS_EDGE_SELECT;
	localparam logic [1:0]  ok    = KPI_RESP_OKAY;
	logic                    clock;
	logic                    rst_b;
	logic                    deep_stop;
	logic                    key_irq;
	logic                    wake_req;
	logic [KPI_NUM_PINS-1:0] want;
	logic [KPI_NUM_PINS-1:0] pins;
	kpi_axi_req_s            req;
	kpi_axi_rsp_s            rsp;
	int                      errors      = 0;
	int                      comparisons = 0;
	int                      cycles      = 0;
	kpi_top #(.NUM_PINS(KPI_NUM_PINS)) i_dut (.CLOCK(clock), .RST_B(rst_b), .AXI_REQ(req),
		.AXI_RSP(rsp), .DEEP_STOP(deep_stop), .KEY_INPUT_PINS(pins), .KEY_IRQ(key_irq),
		.WAKE_REQ(wake_req));
	kpi_keys i_keys (.clock(clock), .want(want), .pins(pins));
	// ==========================================================
	// clock and watchdog
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			test_done();
		end
	end
	// ==========================================================
	// shared tasks
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
	endtask
	// master holds each channel until its own ready is sampled high
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		req.awaddr <= a;
		req.wdata <= {24'h0, d};
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do begin
			@(posedge clock);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (!rsp.bvalid);
		req.bready <= 1'b0;
		chk("bresp", 32'(rsp.bresp), 32'(er));
		@(posedge clock);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic [1:0] er);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do begin
			@(posedge clock);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		req.rready <= 1'b0;
		chk("rresp", 32'(rsp.rresp), 32'(er));
		if (er == ok) chk("rdata", rsp.rdata, {24'h0, exp});
		@(posedge clock);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_reset();
		rd(r_ctl, 8'h00, ok);
		rd(r_pen, 8'h00, ok);
		rd(r_pol, 8'h00, ok);
		rd(12'h00c, 8'h00, KPI_RESP_SLVERR);
		$display("test reset done");
	endtask
	task automatic t_regs();
		wr(r_pen, 8'hff, ok);
		rd(r_pen, 8'hff, ok);
		wr(r_pol, 8'ha5, ok);
		rd(r_pol, 8'ha5, ok);
		wr(r_pen, 8'h00, ok);
		wr(r_ctl, 8'hff, ok);
		rd(r_ctl, 8'h03, ok);
		wr(12'h010, 8'hff, KPI_RESP_SLVERR);
		wr(r_ctl, 8'h00, ok);
		$display("test registers done");
	endtask
	task automatic t_edge(input logic p);
		logic [3:0] idl;
		idl = p ? 4'h0 : 4'hf;
		want <= idl;
		wr(r_pol, {8{p}}, ok);
		wr(r_pen, 8'h0e, ok);
		wr(r_ctl, 8'h06, ok);
		want <= idl ^ 4'h1;
		idle(8);
		rd(r_ctl, 8'h02, ok);
		want <= idl ^ 4'h3;
		idle(8);
		rd(r_ctl, 8'h0a, ok);
		chk("irq", 32'(key_irq), 32'h1);
		wr(r_ctl, 8'h06, ok);
		rd(r_ctl, 8'h02, ok);
		want <= idl ^ 4'h7;
		idle(8);
		rd(r_ctl, 8'h02, ok);
		want <= idl;
		idle(8);
		want <= idl ^ 4'h8;
		idle(8);
		rd(r_ctl, 8'h0a, ok);
		want <= idl;
		wr(r_ctl, 8'h04, ok);
		rd(r_ctl, 8'h00, ok);
		$display("test edge done");
	endtask
	task automatic t_level();
		want <= 4'hf;
		wr(r_pen, 8'h00, ok);
		wr(r_pol, 8'h00, ok);
		wr(r_pen, 8'hf0, ok);
		wr(r_ctl, 8'h05, ok);
		idle(8);
		rd(r_ctl, 8'h01, ok);
		wr(r_pen, 8'h01, ok);
		wr(r_ctl, 8'h05, ok);
		want <= 4'he;
		idle(8);
		rd(r_ctl, 8'h09, ok);
		chk("irq", 32'(key_irq), 32'h0);
		wr(r_ctl, 8'h07, ok);
		rd(r_ctl, 8'h0b, ok);
		chk("wake", 32'(wake_req), 32'h1);
		want <= 4'hf;
		idle(8);
		wr(r_ctl, 8'h07, ok);
		rd(r_ctl, 8'h03, ok);
		$display("test level done");
	endtask
	task automatic t_deep();
		want <= 4'he;
		idle(8);
		chk("irq", 32'(key_irq), 32'h1);
		deep_stop <= 1'b1;
		idle(4);
		deep_stop <= 1'b0;
		want <= 4'hf;
		idle(2);
		chk("irq", 32'(key_irq), 32'h0);
		rd(r_ctl, 8'h00, ok);
		rd(r_pen, 8'h00, ok);
		rd(r_pol, 8'h00, ok);
		$display("test deep stop done");
	endtask
	// ==========================================================
	// main sequence
	initial begin
		rst_b <= 1'b0;
		deep_stop <= 1'b0;
		want <= 4'hf;
		req <= '{wstrb: 4'h1, default: '0};
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		t_reset();
		t_regs();
		t_edge(1'b0);
		t_edge(1'b1);
		t_level();
		t_deep();
		test_done();
	end
endmodule
